// File: core/dcdma_req_sync.sv
// Purpose: Brings the two external request pins into the clock domain and finds rising edges.
// Assumes: Pins are asynchronous to ref_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module dcdma_req_sync (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Pins
	input wire logic [1:0] async_in,
	// Synchronised view
	output logic [1:0] level_o,
	output logic [1:0] rise_o
);
	dcdma_pkg::dcdma_sync_t q, d;

	always_comb begin
		d.s1 = async_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_o = q.s2;
	assign rise_o = q.s2 & ~q.s3;
endmodule // dcdma_req_sync

// File: core/dcdma_top.sv
// Purpose: Two-channel dual-address DMA sequencer with APB registers and request handshake.
// Assumes: Memory port answers with ack (and err) while req is held; APB3 without strobes.
// Notes: Channel 0 wins when both channels are ready in the same cycle.
// Contract
// - Mode bit 5 high: release bus after each transfer, await a new request.
// - Burst mode holds the bus until the count ends, an error, or a mask that suspends it.
// - Mode bit 0 picks external request pin or software requests.
// - External rising edge triggers; burst ignores the pin until the count ends.
// - Request-clear low means ready; requester raises only while low.
// - Cycle stealing raises request-clear after each transfer; final flag marks the end.
// - Burst raises request-clear and final flag together at the end.
// - Dropping the request never aborts; both outputs still rise.
// - Software mode requests continuously and restarts while its bit stays set.
// - No start while the completion flag is still set.
// - Count reached: stop, set completion, keep reason, interrupt only if unmasked.
// - Error on read or write stops, sets flag and reason, records cycle.
// - Mask during transfer suspends after the write, stays busy, resumes on release.
// - Completion flag sets whatever the mask; mask only gates the interrupt.
// - Busy is 1 while running or suspended, 0 after any termination.
// - Addresses: next after normal end or suspend, failing one after error, except the source is already next after a write error.
// - Count decrements only after a successful source read.
// - Any write to the status clear register clears flag, reason and cycle.
// - Each transfer reads the source, then writes the destination next.
// - Addresses advance by the transfer size when incrementing, else stay.
`timescale 1ns/1ns
module dcdma_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory master
	output dcdma_pkg::dcdma_mreq_t mem_o,
	input dcdma_pkg::dcdma_mrsp_t mem_i,
	output logic bus_own,
	// Request handshake
	input wire logic [1:0] transfer_request_in,
	output logic [1:0] request_clear_out,
	output logic [1:0] final_transfer_out,
	// Interrupt requests
	output logic [1:0] dma_irq
);
	dcdma_pkg::dcdma_state_t q, d;
	logic [1:0] req_lvl, req_rise, rdy;
	logic [31:0] rdv;
	logic c, wchi;

	// ****************************************
	// Request pins
	// ****************************************
	dcdma_req_sync u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in(transfer_request_in),
		.level_o(req_lvl),
		.rise_o(req_rise)
	);

	function automatic logic mapped(input logic [11:0] a);
		logic [7:0] o;
		o = a[7:0];
		if (a[11:8] == dcdma_pkg::PAGE_GLOBAL) begin
			mapped = (o == dcdma_pkg::OFF_COMPLETION_STATUS) || (o == dcdma_pkg::OFF_BUSY_STATUS);
		end else if (a[11:8] == dcdma_pkg::PAGE_CH0 || a[11:8] == dcdma_pkg::PAGE_CH1) begin
			mapped = (o == dcdma_pkg::OFF_CHANNEL_MODE) || (o == dcdma_pkg::OFF_SOURCE_ADDRESS) ||
				(o == dcdma_pkg::OFF_DESTINATION_ADDRESS) || (o == dcdma_pkg::OFF_TRANSFER_COUNT) ||
				(o == dcdma_pkg::OFF_STATUS_CLEAR);
		end else begin
			mapped = 1'b0;
		end
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		rdv = '0;
		c = q.cur;
		wchi = (paddr[11:8] == dcdma_pkg::PAGE_CH1);
		// Software writes come first so that any hardware set in the same cycle wins.
		if (psel && penable && pwrite && mapped(paddr) && paddr[11:8] != dcdma_pkg::PAGE_GLOBAL) begin
			case (paddr[7:0])
				dcdma_pkg::OFF_CHANNEL_MODE: begin
					d.ch[wchi].mode = pwdata[dcdma_pkg::MODE_W-1:0];
				end
				dcdma_pkg::OFF_SOURCE_ADDRESS: begin
					d.ch[wchi].sad = pwdata;
				end
				dcdma_pkg::OFF_DESTINATION_ADDRESS: begin
					d.ch[wchi].dad = pwdata;
				end
				dcdma_pkg::OFF_TRANSFER_COUNT: begin
					d.ch[wchi].cnt = pwdata[dcdma_pkg::CNT_W-1:0];
				end
				dcdma_pkg::OFF_STATUS_CLEAR: begin
					d.ch[wchi].flag = 1'b0;
					d.ch[wchi].reason = 1'b0;
					d.ch[wchi].fail = 1'b0;
				end
				default: begin
				end
			endcase
		end
		for (int i = 0; i < 2; i++) begin
			if (!q.ch[i].mode[dcdma_pkg::REQUEST_SOURCE_SELECT_BIT] && req_rise[i] && !q.ch[i].clr) begin
				d.ch[i].pend = 1'b1;
			end
			if (q.ch[i].clr && !req_lvl[i]) begin
				d.ch[i].clr = 1'b0;
				d.ch[i].tc = 1'b0;
			end
			if (!q.ch[i].busy && !q.ch[i].mode[dcdma_pkg::CHANNEL_MASK_BIT] && !q.ch[i].flag && q.ch[i].cnt != '0) begin
				d.ch[i].busy = 1'b1;
			end
			rdy[i] = q.ch[i].busy && !q.ch[i].mode[dcdma_pkg::CHANNEL_MASK_BIT] &&
				(q.ch[i].mode[dcdma_pkg::REQUEST_SOURCE_SELECT_BIT] || q.ch[i].pend);
		end
		case (q.st)
			dcdma_pkg::ST_IDLE: begin
				if (rdy != 2'b00) begin
					c = !rdy[0];
					d.cur = c;
					d.st = dcdma_pkg::ST_READ;
					d.msize = q.ch[c].mode[dcdma_pkg::SIZE_LSB +: 2];
					d.maddr = dcdma_pkg::align(q.ch[c].sad, d.msize);
					d.mwe = 1'b0;
					if (q.ch[c].mode[dcdma_pkg::BURST_SELECT_BIT]) begin
						d.ch[c].pend = 1'b0;
					end
				end
			end
			dcdma_pkg::ST_READ: begin
				if (mem_i.ack && mem_i.err) begin
					d.st = dcdma_pkg::ST_IDLE;
					d.ch[c].busy = 1'b0;
					d.ch[c].flag = 1'b1;
					d.ch[c].reason = 1'b1;
					d.ch[c].fail = 1'b0;
					d.ch[c].pend = 1'b0;
					d.ch[c].clr = 1'b1;
					d.ch[c].tc = 1'b1;
				end else if (mem_i.ack) begin
					d.mdata = mem_i.rdata;
					d.ch[c].cnt = q.ch[c].cnt - 17'h1;
					if (q.ch[c].mode[dcdma_pkg::SRC_INC_BIT]) begin
						d.ch[c].sad = q.ch[c].sad + dcdma_pkg::step(q.msize);
					end
					d.maddr = dcdma_pkg::align(q.ch[c].dad, q.msize);
					d.mwe = 1'b1;
					d.st = dcdma_pkg::ST_WRITE;
				end
			end
			dcdma_pkg::ST_WRITE: begin
				if (mem_i.ack && mem_i.err) begin
					d.st = dcdma_pkg::ST_IDLE;
					d.ch[c].busy = 1'b0;
					d.ch[c].flag = 1'b1;
					d.ch[c].reason = 1'b1;
					d.ch[c].fail = 1'b1;
					d.ch[c].pend = 1'b0;
					d.ch[c].clr = 1'b1;
					d.ch[c].tc = 1'b1;
				end else if (mem_i.ack) begin
					if (q.ch[c].mode[dcdma_pkg::DST_INC_BIT]) begin
						d.ch[c].dad = q.ch[c].dad + dcdma_pkg::step(q.msize);
					end
					d.mwe = 1'b0;
					if (q.ch[c].cnt == '0) begin
						d.st = dcdma_pkg::ST_IDLE;
						d.ch[c].busy = 1'b0;
						d.ch[c].flag = 1'b1;
						d.ch[c].pend = 1'b0;
						d.ch[c].clr = 1'b1;
						d.ch[c].tc = 1'b1;
					end else if (q.ch[c].mode[dcdma_pkg::CHANNEL_MASK_BIT]) begin
						d.st = dcdma_pkg::ST_IDLE;
						d.ch[c].clr = q.ch[c].clr | q.ch[c].mode[dcdma_pkg::BURST_SELECT_BIT];
					end else if (!q.ch[c].mode[dcdma_pkg::BURST_SELECT_BIT]) begin
						d.st = dcdma_pkg::ST_READ;
						d.maddr = dcdma_pkg::align(q.ch[c].sad, q.msize);
					end else begin
						d.st = dcdma_pkg::ST_IDLE;
						d.ch[c].clr = 1'b1;
					end
				end
			end
			default: begin
				d.st = dcdma_pkg::ST_IDLE;
			end
		endcase
		// Read data is captured in the setup phase so the access phase needs no wait state.
		if (paddr[11:8] == dcdma_pkg::PAGE_GLOBAL) begin
			for (int i = 0; i < 2; i++) begin
				if (paddr[7:0] == dcdma_pkg::OFF_COMPLETION_STATUS) begin
					rdv[dcdma_pkg::FLAG_LSB + i] = q.ch[i].flag;
					rdv[dcdma_pkg::REASON_LSB + i] = q.ch[i].reason;
					rdv[dcdma_pkg::FAIL_LSB + i] = q.ch[i].fail;
				end else begin
					rdv[i] = q.ch[i].busy;
				end
			end
		end else begin
			case (paddr[7:0])
				dcdma_pkg::OFF_CHANNEL_MODE: begin
					rdv[dcdma_pkg::MODE_W-1:0] = q.ch[wchi].mode;
				end
				dcdma_pkg::OFF_SOURCE_ADDRESS: begin
					rdv = q.ch[wchi].sad;
				end
				dcdma_pkg::OFF_DESTINATION_ADDRESS: begin
					rdv = q.ch[wchi].dad;
				end
				dcdma_pkg::OFF_TRANSFER_COUNT: begin
					rdv[dcdma_pkg::CNT_W-1:0] = q.ch[wchi].cnt;
				end
				default: begin
				end
			endcase
		end
		if (psel && !penable) begin
			d.prdata = mapped(paddr) ? rdv : '0;
			d.pslverr = !mapped(paddr);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q <= dcdma_pkg::STATE_RST;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = q.prdata;
	assign pready = 1'b1;
	assign pslverr = q.pslverr & psel & penable;
	assign mem_o.req = (q.st != dcdma_pkg::ST_IDLE);
	assign mem_o.we = q.mwe;
	assign mem_o.size = q.msize;
	assign mem_o.addr = q.maddr;
	assign mem_o.wdata = q.mdata;
	assign bus_own = (q.st != dcdma_pkg::ST_IDLE);

	generate
		for (genvar g = 0; g < 2; g++) begin : g_ch
			assign request_clear_out[g] = q.ch[g].clr;
			assign final_transfer_out[g] = q.ch[g].tc;
			assign dma_irq[g] = q.ch[g].flag & ~q.ch[g].mode[dcdma_pkg::CHANNEL_MASK_BIT];
		end
	endgenerate

	// ****************************************
	// Checks
	// ****************************************
	property p_dual;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_READ && mem_i.ack && !mem_i.err) |=> (q.st == dcdma_pkg::ST_WRITE && mem_o.we);
	endproperty
	a_dual: assert property (p_dual) else $error("Write did not follow a good read.");
	property p_cnt;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_READ && mem_i.ack && !mem_i.err) |=> (q.ch[q.cur].cnt == $past(q.ch[q.cur].cnt) - 1);
	endproperty
	a_cnt: assert property (p_cnt) else $error("Count did not drop by one after a read.");
	property p_rd_err;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_READ && mem_i.ack && mem_i.err) |=> (q.ch[q.cur].flag && q.ch[q.cur].reason &&
			!q.ch[q.cur].fail && !q.ch[q.cur].busy && $stable(q.ch[q.cur].cnt) && !bus_own);
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("Read error not handled.");
	property p_wr_err;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_WRITE && mem_i.ack && mem_i.err) |=> (q.ch[q.cur].fail && q.ch[q.cur].reason &&
			$stable(q.ch[q.cur].dad) && request_clear_out[q.cur] && final_transfer_out[q.cur]);
	endproperty
	a_wr_err: assert property (p_wr_err) else $error("Write error not handled.");
	property p_done;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_WRITE && mem_i.ack && !mem_i.err && q.ch[q.cur].cnt == '0) |=>
			(q.ch[q.cur].flag && !q.ch[q.cur].busy && $stable(q.ch[q.cur].reason) &&
			request_clear_out[q.cur] && final_transfer_out[q.cur]);
	endproperty
	a_done: assert property (p_done) else $error("Normal end not handled.");
	property p_burst;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_WRITE && mem_i.ack && !mem_i.err && q.ch[q.cur].cnt != '0 &&
			!q.ch[q.cur].mode[dcdma_pkg::CHANNEL_MASK_BIT] && !q.ch[q.cur].mode[dcdma_pkg::BURST_SELECT_BIT]) |=>
			(q.st == dcdma_pkg::ST_READ && bus_own && !request_clear_out[q.cur]);
	endproperty
	a_burst: assert property (p_burst) else $error("Burst released the bus.");
	property p_steal;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_WRITE && mem_i.ack && !mem_i.err && q.ch[q.cur].cnt != '0 &&
			!q.ch[q.cur].mode[dcdma_pkg::CHANNEL_MASK_BIT] && q.ch[q.cur].mode[dcdma_pkg::BURST_SELECT_BIT]) |=>
			(!bus_own && request_clear_out[q.cur]);
	endproperty
	a_steal: assert property (p_steal) else $error("Cycle stealing kept the bus.");
	property p_suspend;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_WRITE && mem_i.ack && !mem_i.err && q.ch[q.cur].cnt != '0 &&
			q.ch[q.cur].mode[dcdma_pkg::CHANNEL_MASK_BIT]) |=> (!bus_own && q.ch[q.cur].busy && !q.ch[q.cur].flag) [*2];
	endproperty
	a_suspend: assert property (p_suspend) else $error("Masked channel did not suspend.");
	property p_block;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_IDLE && q.ch[0].flag && !q.ch[0].busy) |=> !(q.st == dcdma_pkg::ST_READ && !q.cur);
	endproperty
	a_block: assert property (p_block) else $error("Channel started with status set.");
	property p_src_inc;
		@(posedge ref_clk) disable iff (!rst_n)
		(q.st == dcdma_pkg::ST_READ && mem_i.ack && !mem_i.err && q.ch[q.cur].mode[dcdma_pkg::SRC_INC_BIT]) |=>
			(q.ch[q.cur].sad == $past(q.ch[q.cur].sad) + dcdma_pkg::step($past(q.msize)));
	endproperty
	a_src_inc: assert property (p_src_inc) else $error("Source address did not advance.");
	property p_irq_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		(psel && penable && pwrite && paddr == {dcdma_pkg::PAGE_CH0, dcdma_pkg::OFF_STATUS_CLEAR} &&
			!(q.st == dcdma_pkg::ST_WRITE && mem_i.ack) && !(q.st == dcdma_pkg::ST_READ && mem_i.ack))
			|=> !dma_irq[0] && !q.ch[0].flag;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("Status clear left channel 0 flagged.");
endmodule // dcdma_top

// File: pkg/dcdma_pkg.sv
// Purpose: Shared constants, types and helpers of the two-channel DMA control block.
// Assumes: APB register access, one clock, a simple request/acknowledge memory port.
// Notes: Offsets are byte addresses within a 256-byte page, paddr[11:8] picks the page.
package dcdma_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] PAGE_GLOBAL = 4'h0;
	localparam logic [3:0] PAGE_CH0 = 4'h1;
	localparam logic [3:0] PAGE_CH1 = 4'h2;
	localparam logic [7:0] OFF_COMPLETION_STATUS = 8'h04;
	localparam logic [7:0] OFF_BUSY_STATUS = 8'h08;
	localparam logic [7:0] OFF_CHANNEL_MODE = 8'h00;
	localparam logic [7:0] OFF_SOURCE_ADDRESS = 8'h04;
	localparam logic [7:0] OFF_DESTINATION_ADDRESS = 8'h08;
	localparam logic [7:0] OFF_TRANSFER_COUNT = 8'h10;
	localparam logic [7:0] OFF_STATUS_CLEAR = 8'h14;
	// ****************************************
	// Field layout
	// ****************************************
	localparam int MODE_W = 7;
	localparam int REQUEST_SOURCE_SELECT_BIT = 0;
	localparam int SIZE_LSB = 1;
	localparam int SRC_INC_BIT = 3;
	localparam int DST_INC_BIT = 4;
	localparam int BURST_SELECT_BIT = 5;
	localparam int CHANNEL_MASK_BIT = 6;
	localparam int CNT_W = 17;
	localparam int FLAG_LSB = 0;
	localparam int REASON_LSB = 8;
	localparam int FAIL_LSB = 16;
	localparam logic [MODE_W-1:0] MODE_RST = 7'h00;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} dcdma_st_t;
	typedef struct packed {
		logic [MODE_W-1:0] mode;
		logic [31:0] sad;
		logic [31:0] dad;
		logic [CNT_W-1:0] cnt;
		logic busy;
		logic flag;
		logic reason;
		logic fail;
		logic pend;
		logic clr;
		logic tc;
	} dcdma_chan_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dcdma_mreq_t;
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} dcdma_mrsp_t;
	typedef struct packed {
		dcdma_st_t st;
		logic cur;
		dcdma_chan_t [1:0] ch;
		logic [31:0] maddr;
		logic mwe;
		logic [1:0] msize;
		logic [31:0] mdata;
		logic [31:0] prdata;
		logic pslverr;
	} dcdma_state_t;
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
	} dcdma_sync_t;
	localparam dcdma_state_t STATE_RST = '{st: ST_IDLE, default: '0};
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] step(input logic [1:0] sz);
		step = (sz == SZ_WORD) ? 32'h4 : (sz == SZ_HALF) ? 32'h2 : 32'h1;
	endfunction
	function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
		align = a & ~(step(sz) - 32'h1);
	endfunction
endpackage

// File: sim/dcdma_req_model.sv
// Purpose: External requester model that drives the two request pins.
// Assumes: The block samples the pins through its own synchroniser.
// Notes: Slow mode waits a few cycles before each new request.
`timescale 1ns/1ns
module dcdma_req_model (
	// Clock
	input wire logic ref_clk,
	// Bench control
	input wire logic [1:0] go,
	input wire logic slow,
	// Handshake
	input wire logic [1:0] request_clear_out,
	input wire logic [1:0] final_transfer_out,
	output logic [1:0] transfer_request_in
);
	logic [2:0] wait_q [2];
	logic [1:0] done_q;
	initial begin
		transfer_request_in = 2'h0;
		done_q = 2'h0;
		wait_q = '{3'h0, 3'h0};
	end
	// ****
	// Requester
	// ****
	// A finished channel gets no further edges, so no stray request is left pending.
	always @(posedge ref_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (!go[i]) begin
				done_q[i] <= 1'b0;
			end
			if (transfer_request_in[i] && request_clear_out[i]) begin
				transfer_request_in[i] <= 1'b0;
				done_q[i] <= final_transfer_out[i];
				wait_q[i] <= slow ? 3'h5 : 3'h0;
			end else if (wait_q[i] != 3'h0) begin
				wait_q[i] <= wait_q[i] - 3'h1;
			end else if (go[i] && !done_q[i] && !transfer_request_in[i] && !request_clear_out[i]) begin
				transfer_request_in[i] <= 1'b1;
			end
		end
	end
endmodule // dcdma_req_model

// File: sim/dual_channel_dma_control_tb_top.sv
// Purpose: Self-checking bench of the two-channel DMA block.
// Assumes: Zero-wait APB and a memory that stalls at random.
// Notes: Memory data is a fixed pattern of the address.
`timescale 1ns/1ns
module dual_channel_dma_control_tb_top;
	logic ref_clk = 1'b0;
	logic rst_n, psel, penable, pwrite, pready, pslverr, bus_own, own_q, last_err, slow, ack_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v, seed, last_rd, s, d;
	logic [31:0] mseed = 32'h0001_5681;
	dcdma_pkg::dcdma_mreq_t mem_o;
	dcdma_pkg::dcdma_mrsp_t mem_i;
	logic [1:0] transfer_request_in, request_clear_out, final_transfer_out, dma_irq, go, clr_q, tc_q;
	logic [32:0] log_q [$];
	int errors = 0, compares = 0, acks = 0, err_at = -1, falls = 0, b, f0, r0, t0, n, c;
	int clr_rise [2] = '{0, 0};
	int tc_rise [2] = '{0, 0};
	always #2 ref_clk = ~ref_clk;
	dcdma_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_o(mem_o),
		.mem_i(mem_i), .bus_own(bus_own), .transfer_request_in(transfer_request_in),
		.request_clear_out(request_clear_out), .final_transfer_out(final_transfer_out), .dma_irq(dma_irq));
	dcdma_req_model partner (.ref_clk(ref_clk), .go(go), .slow(slow), .request_clear_out(request_clear_out),
		.final_transfer_out(final_transfer_out), .transfer_request_in(transfer_request_in));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		lfsr = v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
	endfunction
	function automatic logic [31:0] pat(input logic [31:0] a);
		pat = a ^ 32'hc3a5_0f96;
	endfunction
	function automatic logic [31:0] md(input logic sw, input logic [1:0] sz, input logic si, di, cs, mk);
		md = {25'h0, mk, cs, di, si, sz, sw};
	endfunction
	function automatic logic [11:0] ca(input int ch, input logic [7:0] o);
		ca = {(ch == 1) ? dcdma_pkg::PAGE_CH1 : dcdma_pkg::PAGE_CH0, o};
	endfunction
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setup(input int ch, input logic [31:0] m, sa, da, cnt);
		apb(1'b1, ca(ch, dcdma_pkg::OFF_CHANNEL_MODE), m | 32'h40);
		apb(1'b1, ca(ch, dcdma_pkg::OFF_STATUS_CLEAR), seed);
		apb(1'b1, ca(ch, dcdma_pkg::OFF_CHANNEL_MODE), m | 32'h40);
		apb(1'b1, ca(ch, dcdma_pkg::OFF_SOURCE_ADDRESS), sa);
		apb(1'b1, ca(ch, dcdma_pkg::OFF_DESTINATION_ADDRESS), da);
		apb(1'b1, ca(ch, dcdma_pkg::OFF_TRANSFER_COUNT), cnt);
		apb(1'b1, ca(ch, dcdma_pkg::OFF_CHANNEL_MODE), m);
	endtask
	task automatic wait_idle(input int ch);
		do begin
			apb(1'b0, {dcdma_pkg::PAGE_GLOBAL, dcdma_pkg::OFF_BUSY_STATUS}, 32'h0);
		end while (rd_v[ch] !== 1'b0);
	endtask
	task automatic status(input int ch, input logic f, r, p, input logic [31:0] cnt, sa, da);
		apb(1'b0, {dcdma_pkg::PAGE_GLOBAL, dcdma_pkg::OFF_COMPLETION_STATUS}, 32'h0);
		chk(rd_v & (32'h0001_0101 << ch), {15'h0, p, 7'h0, r, 7'h0, f} << ch);
		apb(1'b0, ca(ch, dcdma_pkg::OFF_TRANSFER_COUNT), 32'h0);
		chk(rd_v, cnt);
		apb(1'b0, ca(ch, dcdma_pkg::OFF_SOURCE_ADDRESS), 32'h0);
		chk(rd_v, sa);
		apb(1'b0, ca(ch, dcdma_pkg::OFF_DESTINATION_ADDRESS), 32'h0);
		chk(rd_v, da);
		chk(dma_irq[ch], f);
	endtask
	task automatic log_chk(input int lb, input logic [31:0] sa, da, input int cnt, st, input logic si, di);
		for (int i = 0; i < cnt; i++) begin
			chk(log_q[lb + 2 * i], {1'b0, sa + 32'(si ? i * st : 0)});
			chk(log_q[lb + 2 * i + 1], {1'b1, da + 32'(di ? i * st : 0)});
		end
	endtask
	// ****
	// Memory and pin monitor
	// ****
	always @(posedge ref_clk) begin
		ack_n = mem_o.req && !mem_i.ack && mseed[0];
		mseed <= lfsr(mseed);
		mem_i.ack <= ack_n;
		mem_i.err <= ack_n && (acks == err_at);
		mem_i.rdata <= ack_n ? pat(mem_o.addr) : ~mem_i.rdata;
		acks <= acks + int'(ack_n);
		own_q <= bus_own;
		clr_q <= request_clear_out;
		tc_q <= final_transfer_out;
		falls <= falls + int'(own_q && !bus_own);
		for (int i = 0; i < 2; i++) begin
			clr_rise[i] <= clr_rise[i] + int'(request_clear_out[i] && !clr_q[i]);
			tc_rise[i] <= tc_rise[i] + int'(final_transfer_out[i] && !tc_q[i]);
			if (final_transfer_out[i] && !tc_q[i])
				chk(request_clear_out[i] & ~clr_q[i], 1'b1);
		end
		if (mem_o.req && mem_i.ack) begin
			log_q.push_back({mem_o.we, mem_o.addr});
			if (!mem_o.we)
				last_rd <= mem_o.addr;
			else if (mem_o.size == dcdma_pkg::SZ_WORD)
				chk(mem_o.wdata, pat(last_rd));
		end
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		errors++;
		tally_and_finish;
	end
	// ****
	// Scenarios
	// ****
	initial begin
		{psel, penable, pwrite, paddr, pwdata, slow, go} = '0;
		mem_i = '0;
		rst_n = 1'b0;
		seed = 32'h0001_5681;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b0, {dcdma_pkg::PAGE_GLOBAL, dcdma_pkg::OFF_BUSY_STATUS}, 32'h0);
		chk(rd_v, 32'h0);
		apb(1'b0, 12'h3f0, 32'h0);
		chk(last_err, 1'b1);
		b = log_q.size();
		f0 = falls;
		setup(0, md(1'b1, dcdma_pkg::SZ_WORD, 1'b1, 1'b1, 1'b0, 1'b0), 32'h1000, 32'h2000, 32'h3);
		wait_idle(0);
		status(0, 1'b1, 1'b0, 1'b0, 32'h0, 32'h100c, 32'h200c);
		chk(falls - f0, 1);
		log_chk(b, 32'h1000, 32'h2000, 3, 4, 1'b1, 1'b1);
		apb(1'b1, ca(0, dcdma_pkg::OFF_CHANNEL_MODE), md(1'b1, dcdma_pkg::SZ_WORD, 1'b1, 1'b1, 1'b0, 1'b1));
		apb(1'b0, {dcdma_pkg::PAGE_GLOBAL, dcdma_pkg::OFF_COMPLETION_STATUS}, 32'h0);
		chk({rd_v[0], dma_irq[0]}, 2'b10);
		apb(1'b1, ca(0, dcdma_pkg::OFF_TRANSFER_COUNT), 32'h2);
		apb(1'b1, ca(0, dcdma_pkg::OFF_CHANNEL_MODE), md(1'b1, dcdma_pkg::SZ_WORD, 1'b1, 1'b1, 1'b0, 1'b0));
		repeat (20) @(posedge ref_clk);
		chk(33'(log_q.size()), 33'(b + 6));
		apb(1'b1, ca(0, dcdma_pkg::OFF_STATUS_CLEAR), seed);
		wait_idle(0);
		status(0, 1'b1, 1'b0, 1'b0, 32'h0, 32'h1014, 32'h2014);
		for (int e = 0; e < 2; e++) begin
			err_at = acks + 2 + e;
			setup(0, md(1'b1, dcdma_pkg::SZ_WORD, 1'b1, 1'b1, 1'b0, 1'b0), 32'h3000, 32'h4000, 32'h2);
			wait_idle(0);
			status(0, 1'b1, 1'b1, e[0], 32'(1 - e), 32'h3004 + 32'(4 * e), 32'h4004);
		end
		err_at = -1;
		b = log_q.size();
		setup(0, md(1'b1, dcdma_pkg::SZ_WORD, 1'b1, 1'b1, 1'b0, 1'b0), 32'h5000, 32'h6000, 32'h8);
		apb(1'b1, ca(0, dcdma_pkg::OFF_CHANNEL_MODE), md(1'b1, dcdma_pkg::SZ_WORD, 1'b1, 1'b1, 1'b0, 1'b1));
		repeat (20) @(posedge ref_clk);
		apb(1'b0, {dcdma_pkg::PAGE_GLOBAL, dcdma_pkg::OFF_BUSY_STATUS}, 32'h0);
		chk(rd_v[0], 1'b1);
		n = (log_q.size() - b) / 2;
		chk(33'((log_q.size() - b) % 2), 33'h0);
		status(0, 1'b0, 1'b0, 1'b0, 32'(8 - n), 32'h5000 + 32'(4 * n), 32'h6000 + 32'(4 * n));
		apb(1'b1, ca(0, dcdma_pkg::OFF_CHANNEL_MODE), md(1'b1, dcdma_pkg::SZ_WORD, 1'b1, 1'b1, 1'b0, 1'b0));
		wait_idle(0);
		status(0, 1'b1, 1'b0, 1'b0, 32'h0, 32'h5020, 32'h6020);
		log_chk(b, 32'h5000, 32'h6000, 8, 4, 1'b1, 1'b1);
		for (int m = 0; m < 2; m++) begin
			b = log_q.size();
			f0 = falls;
			r0 = clr_rise[1 - m];
			t0 = tc_rise[1 - m];
			slow <= !m[0];
			setup(1 - m, md(1'b0, m ? dcdma_pkg::SZ_BYTE : dcdma_pkg::SZ_HALF, m[0], 1'b1, !m[0], 1'b0),
				32'h7002, 32'h8000, 32'h3);
			go <= m ? 2'b01 : 2'b10;
			wait_idle(1 - m);
			repeat (4) @(posedge ref_clk);
			go <= 2'b00;
			chk(falls - f0, m ? 1 : 3);
			chk(clr_rise[1 - m] - r0, m ? 1 : 3);
			chk(tc_rise[1 - m] - t0, 1);
			status(1 - m, 1'b1, 1'b0, 1'b0, 32'h0, m ? 32'h7005 : 32'h7002, m ? 32'h8003 : 32'h8006);
			log_chk(b, 32'h7002, 32'h8000, 3, m ? 1 : 2, m[0], 1'b1);
		end
		for (int k = 0; k < 6; k++) begin
			c = k % 2;
			seed = lfsr(seed);
			n = 1 + int'(seed[1:0]);
			s = {16'h0001, seed[13:2], 4'h0};
			d = {16'h0002, seed[29:18], 4'h0};
			b = log_q.size();
			setup(c, md(1'b1, dcdma_pkg::SZ_WORD, seed[20], seed[21], seed[22], 1'b0), s, d, 32'(n));
			wait_idle(c);
			status(c, 1'b1, 1'b0, 1'b0, 32'h0, s + (seed[20] ? 32'(4 * n) : 32'h0),
				d + (seed[21] ? 32'(4 * n) : 32'h0));
			log_chk(b, s, d, n, 4, seed[20], seed[21]);
		end
		tally_and_finish;
	end
endmodule // dual_channel_dma_control_tb_top
